/* verilog/fdtc_fan_ctrl.sv */
// chassis fan duty control from temperature, with fan speed alarm
`timescale 1ns/1ns
`include "fdtc_regs.svh"
module fdtc_fan_ctrl (
	// clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic clk_en_in,
	// rear panel pins: speed selector and chassis variant strap
	input wire logic speed_high_in,
	input wire logic three_fan_in,
	// sensor readings and tach speeds, same clock domain
	input wire fdtc_pkg::fdtc_sensors_t sensors_in,
	input wire fdtc_pkg::fdtc_tach_t tach_in,
	// software settings
	input wire fdtc_pkg::fdtc_settings_t settings_in,
	// fan drive and status
	output logic fan_pwm_out,
	output fdtc_pkg::fdtc_status_t status_out
);
	logic high_meta_q;
	logic high_q;
	logic var_meta_q;
	logic var_q;
	logic init_q;
	logic three_fan_q;
	fdtc_pkg::fdtc_mode_t mode_w;
	fdtc_pkg::fdtc_temp_t max_w [0:`FDTC_NUM_SENSORS-1];
	fdtc_pkg::fdtc_temp_t hottest_q;
	logic [6:0] setpoint_q;
	logic [15:0] limit_q;
	logic alarm_en_q;
	logic alarm_q;
	logic [`FDTC_NUM_FANS-1:0] slow_w;
	logic fault_w;
	logic signed [9:0] diff_w;
	logic [9:0] drop_w;
	fdtc_pkg::fdtc_pct_t duty_d;
	fdtc_pkg::fdtc_pct_t duty_q;

	// two-stage synchronisers for the rear panel pins
	always_ff @(posedge clk_in) begin
		if (clk_en_in) begin
			high_meta_q <= speed_high_in;
			high_q <= high_meta_q;
			var_meta_q <= three_fan_in;
			var_q <= var_meta_q;
		end
	end

	assign mode_w = high_q ? fdtc_pkg::FDTC_MODE_HIGH : fdtc_pkg::FDTC_MODE_AUTO;

	// hottest sensor by a compare chain
	assign max_w[0] = sensors_in.temp[0];
	for (genvar g = 1; g < `FDTC_NUM_SENSORS; g++) begin : g_max
		assign max_w[g] = (sensors_in.temp[g] > max_w[g-1]) ? sensors_in.temp[g] : max_w[g-1];
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			hottest_q <= 8'sh00;
		end else if (clk_en_in) begin
			hottest_q <= max_w[`FDTC_NUM_SENSORS-1];
		end
	end

	// setpoint: out-of-range writes are ignored
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			setpoint_q <= `FDTC_SP_DEFAULT;
		end else if (clk_en_in && settings_in.setpoint_wr &&
			settings_in.setpoint >= `FDTC_SP_MIN && settings_in.setpoint <= `FDTC_SP_MAX) begin
			setpoint_q <= settings_in.setpoint;
		end
	end

	// variant strap caught in the first enabled cycle after reset
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			init_q <= 1'b1;
			three_fan_q <= 1'b0;
		end else if (clk_en_in && init_q) begin
			init_q <= 1'b0;
			three_fan_q <= var_q;
		end
	end

	// alarm limit: power-on default, then software writes
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			limit_q <= 16'h0000;
		end else if (clk_en_in) begin
			if (init_q) begin
				limit_q <= var_q ? `FDTC_LIMIT_THREE_FAN : `FDTC_LIMIT_TWO_FAN;
			end else if (settings_in.limit_wr) begin
				limit_q <= settings_in.limit;
			end
		end
	end

	// alarm enable setting
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			alarm_en_q <= 1'b0;
		end else if (clk_en_in) begin
			alarm_en_q <= settings_in.alarm_en;
		end
	end

	// per fan slow detection; the third fan exists only on the larger chassis
	for (genvar g = 0; g < `FDTC_NUM_FANS; g++) begin : g_slow
		assign slow_w[g] = (tach_in.rpm[g] < limit_q) && ((g != 2) || three_fan_q);
	end

	assign fault_w = alarm_en_q && !init_q && (|slow_w);

	// sticky alarm; a fault in the clear cycle wins
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			alarm_q <= 1'b0;
		end else if (clk_en_in) begin
			if (fault_w) begin
				alarm_q <= 1'b1;
			end else if (settings_in.alarm_clear) begin
				alarm_q <= 1'b0;
			end
		end
	end

	// open-loop temperature to duty map, no feedback on temperature
	assign diff_w = $signed({3'b000, setpoint_q}) - 10'(hottest_q);
	assign drop_w = 10'((diff_w * $signed(`FDTC_SLOPE_NUM)) / $signed(`FDTC_SLOPE_DEN));

	always_comb begin
		duty_d = `FDTC_DUTY_FULL;
		case (mode_w)
			fdtc_pkg::FDTC_MODE_HIGH: begin
				duty_d = `FDTC_DUTY_FULL;
			end
			fdtc_pkg::FDTC_MODE_AUTO: begin
				if (diff_w <= 10'sd0) begin
					duty_d = `FDTC_DUTY_FULL;
				end else if (diff_w >= $signed(`FDTC_RAMP_SPAN)) begin
					duty_d = `FDTC_DUTY_MIN;
				end else begin
					duty_d = `FDTC_DUTY_FULL - 7'(drop_w);
				end
			end
			default: begin
				duty_d = `FDTC_DUTY_FULL;
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			duty_q <= `FDTC_DUTY_FULL;
		end else if (clk_en_in) begin
			duty_q <= duty_d;
		end
	end

	fdtc_pwm u_pwm (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.clk_en_in(clk_en_in),
		.duty_in(duty_q),
		.pwm_out(fan_pwm_out)
	);

	// status gathered from registers
	assign status_out.duty = duty_q;
	assign status_out.hottest = hottest_q;
	assign status_out.setpoint = setpoint_q;
	assign status_out.limit = limit_q;
	assign status_out.alarm_en = alarm_en_q;
	assign status_out.alarm = alarm_q;

	high_full_duty_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(clk_en_in && high_q) |=> duty_q == `FDTC_DUTY_FULL)
		else $error("high switch without full duty");

	auto_floor_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(clk_en_in && !high_q) |=> duty_q >= `FDTC_DUTY_MIN)
		else $error("auto duty below floor");

	at_setpoint_full_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(clk_en_in && !high_q && $signed({1'b0, setpoint_q}) <= hottest_q)
		|=> duty_q == `FDTC_DUTY_FULL)
		else $error("no full duty at or above setpoint");

	ramp_start_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(clk_en_in && !high_q && diff_w >= 10'sd25) |=> duty_q == `FDTC_DUTY_MIN)
		else $error("duty above floor before ramp start");

	ramp_inside_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(clk_en_in && !high_q && diff_w > 10'sd0 && diff_w < 10'sd25)
		|=> duty_q > `FDTC_DUTY_MIN && duty_q < `FDTC_DUTY_FULL)
		else $error("ramp duty out of band");

	setpoint_range_a: assert property (@(posedge clk_in) disable iff (reset_in)
		setpoint_q >= `FDTC_SP_MIN && setpoint_q <= `FDTC_SP_MAX)
		else $error("setpoint out of range");

	// checked at the first edge after release, so no history is needed at time zero
	setpoint_default_a: assert property (@(posedge clk_in)
		$fell(reset_in) |-> setpoint_q == `FDTC_SP_DEFAULT)
		else $error("setpoint default wrong");

	default_limit_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(clk_en_in && init_q) |=> limit_q == ($past(var_q) ? 16'h04b0 : 16'h0384))
		else $error("default alarm limit wrong");

	alarm_sticky_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(alarm_q && !(clk_en_in && settings_in.alarm_clear)) |=> alarm_q)
		else $error("alarm dropped without clear");

	alarm_raise_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(clk_en_in && alarm_en_q && !init_q && tach_in.rpm[0] < limit_q) |=> alarm_q)
		else $error("slow fan did not raise alarm");

endmodule // fdtc_fan_ctrl

/* verilog/fdtc_regs.svh */
// constants of the chassis fan duty and temperature control block
// Functional notes
// - first enabled cycle after reset loads 900 or 1200 RPM limit (reset itself loads 0)
// - HIGH switch forces 100% duty
// - AUTO derives duty from temperature and setpoint
// - hottest of eight sensors controls duty
// - setpoint accepts 25 to 65 C, 1 C steps
// - setpoint defaults to 50 C
// - ramp starts 25 C below setpoint
// - duty reaches 100% at setpoint
// - open-loop mapping, no temperature regulation
// - writable speed limit and alarm enable
// - alarm flag sticky until software clear
// - AUTO duty never below 40%
// - duty reduction proportional to distance below setpoint
// - enabled alarm rises when fan too slow
`ifndef FDTC_REGS_SVH
`define FDTC_REGS_SVH

// sensor and fan counts
`define FDTC_NUM_SENSORS 8
`define FDTC_NUM_FANS 3

// duty figures in percent
`define FDTC_DUTY_FULL 7'h64
`define FDTC_DUTY_MIN 7'h28

// ramp below the setpoint: 25 C span, slope 60/25 = 12/5 percent per C
`define FDTC_RAMP_SPAN 10'h019
`define FDTC_SLOPE_NUM 10'h00c
`define FDTC_SLOPE_DEN 10'h005

// full-speed setpoint range and reset value in C
`define FDTC_SP_MIN 7'h19
`define FDTC_SP_MAX 7'h41
`define FDTC_SP_DEFAULT 7'h32

// default minimum speed alarm limits in RPM
`define FDTC_LIMIT_TWO_FAN 16'h0384
`define FDTC_LIMIT_THREE_FAN 16'h04b0

// pwm timing: 125 MHz clock, 25 kHz pwm, 100 steps per period
`define FDTC_CLK_KHZ 125000
`define FDTC_PWM_KHZ 25
`define FDTC_PWM_STEPS 7'h64
`define FDTC_PWM_DIV (`FDTC_CLK_KHZ / (`FDTC_PWM_KHZ * 100))

`endif

/* verilog/fdtc_pkg.sv */
// types of the chassis fan duty and temperature control block
package fdtc_pkg;

	typedef logic signed [7:0] fdtc_temp_t;

	typedef logic [6:0] fdtc_pct_t;

	typedef enum logic {FDTC_MODE_AUTO, FDTC_MODE_HIGH} fdtc_mode_t;

	typedef struct packed {
		fdtc_temp_t [7:0] temp;
	} fdtc_sensors_t;

	typedef struct packed {
		logic [2:0][15:0] rpm;
	} fdtc_tach_t;

	typedef struct packed {
		logic [6:0] setpoint;
		logic setpoint_wr;
		logic [15:0] limit;
		logic limit_wr;
		logic alarm_en;
		logic alarm_clear;
	} fdtc_settings_t;

	typedef struct packed {
		fdtc_pct_t duty;
		fdtc_temp_t hottest;
		logic [6:0] setpoint;
		logic [15:0] limit;
		logic alarm_en;
		logic alarm;
	} fdtc_status_t;

endpackage

/* verilog/fdtc_pwm.sv */
// pwm generator turning a duty percentage into the fan drive pin
`timescale 1ns/1ns
`include "fdtc_regs.svh"
module fdtc_pwm (
	// clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic clk_en_in,
	// duty in percent
	input wire logic [6:0] duty_in,
	// fan drive
	output logic pwm_out
);
	localparam logic [5:0] DIV_LAST = 6'(`FDTC_PWM_DIV - 1);

	logic [5:0] pre_q;
	logic [6:0] step_q;
	logic pwm_q;

	// prescaler sets the step rate
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			pre_q <= 6'h00;
		end else if (clk_en_in) begin
			pre_q <= (pre_q == DIV_LAST) ? 6'h00 : pre_q + 6'h01;
		end
	end

	// step counter walks 0..99
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			step_q <= 7'h00;
		end else if (clk_en_in && pre_q == DIV_LAST) begin
			step_q <= (step_q == `FDTC_PWM_STEPS - 7'h01) ? 7'h00 : step_q + 7'h01;
		end
	end

	// drive high while step below duty; full drive during reset
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			pwm_q <= 1'b1;
		end else if (clk_en_in) begin
			pwm_q <= step_q < duty_in;
		end
	end

	assign pwm_out = pwm_q;

	pwm_full_high_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(clk_en_in && duty_in >= `FDTC_DUTY_FULL) |=> pwm_q)
		else $error("pwm low at full duty");

endmodule // fdtc_pwm

/* testbench/fdtc_env_model.sv */
// far-side model: eight temperature sensors and three fan tachs
`timescale 1ns/1ns
module fdtc_env_model (
	// scenario controls
	input wire logic [2:0] hot_idx_in,
	input wire fdtc_pkg::fdtc_temp_t hot_in,
	input wire fdtc_pkg::fdtc_temp_t cool_in,
	input wire logic [1:0] slow_fan_in,
	input wire logic [15:0] slow_rpm_in,
	// sensor and tach outputs
	output fdtc_pkg::fdtc_sensors_t sensors_out,
	output fdtc_pkg::fdtc_tach_t tach_out
);
	// one hot sensor among cooler ones
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			sensors_out.temp[i] = (i == hot_idx_in) ? hot_in : cool_in;
		end
	end
	// healthy fans at 2000 rpm unless one is slowed
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			tach_out.rpm[i] = (i == slow_fan_in) ? slow_rpm_in : 16'h07d0;
		end
	end
endmodule // fdtc_env_model

/* testbench/tb.sv */
// self-checking bench for the fan duty and temperature control
`timescale 1ns/1ns
module tb;
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic clk_en_in = 1'b1;
	logic speed_high_in = 1'b0;
	logic three_fan_in = 1'b1;
	logic [2:0] hot_idx = 3'h0;
	fdtc_pkg::fdtc_temp_t hot = 8'h14;
	fdtc_pkg::fdtc_temp_t cool = 8'h14;
	logic [1:0] slow_fan = 2'h3;
	logic [15:0] slow_rpm = 16'h0000;
	fdtc_pkg::fdtc_settings_t settings = '0;
	fdtc_pkg::fdtc_sensors_t sensors;
	fdtc_pkg::fdtc_tach_t tach;
	fdtc_pkg::fdtc_status_t status;
	logic fan_pwm;
	int errors = 0;
	int comparisons = 0;

	// 125 MHz clock
	initial begin
		forever #4 clk_in = ~clk_in;
	end

	fdtc_env_model fdtc_env_model_i (.hot_idx_in(hot_idx), .hot_in(hot), .cool_in(cool),
		.slow_fan_in(slow_fan), .slow_rpm_in(slow_rpm), .sensors_out(sensors),
		.tach_out(tach));
	fdtc_fan_ctrl fdtc_fan_ctrl_i (.clk_in(clk_in), .reset_in(reset_in),
		.clk_en_in(clk_en_in), .speed_high_in(speed_high_in), .three_fan_in(three_fan_in),
		.sensors_in(sensors), .tach_in(tach), .settings_in(settings),
		.fan_pwm_out(fan_pwm), .status_out(status));

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic stop_test();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic do_reset(input logic strap);
		three_fan_in = strap;
		reset_in = 1'b1;
		cyc(16);
		reset_in = 1'b0;
		cyc(3);
	endtask
	task automatic wr_sp(input logic [6:0] v, input logic en);
		settings.setpoint = v;
		settings.setpoint_wr = 1'b1;
		clk_en_in = en;
		cyc(1);
		settings.setpoint_wr = 1'b0;
		clk_en_in = 1'b1;
		cyc(2);
	endtask
	task automatic wait_alarm();
		comparisons++;
		for (int i = 0; i < 10; i++) begin
			cyc(1);
			if (status.alarm === 1'b1) return;
		end
		errors++;
		$display("FAIL alarm expected 1 seen %b", status.alarm);
		stop_test();
	endtask
	// duty expected from setpoint and hottest reading
	function automatic logic [6:0] exp_duty(input int sp, input int t);
		int d;
		d = sp - t;
		if (d <= 0) return 7'h64;
		if (d >= 25) return 7'h28;
		return 7'(100 - d * 12 / 5);
	endfunction

	// default limit per variant, default setpoint
	task automatic t_defaults();
		do_reset(1'b0);
		chk("limit two-fan", 16'h0384, status.limit);
		do_reset(1'b1);
		chk("limit three-fan", 16'h04b0, status.limit);
		chk("setpoint default", 16'h0032, 16'(status.setpoint));
	endtask
	// range edges refused or taken, disabled clock ignored
	task automatic t_setpoint();
		logic [6:0] tries [5] = '{7'h18, 7'h19, 7'h42, 7'h41, 7'h1e};
		logic [6:0] want [5] = '{7'h32, 7'h19, 7'h19, 7'h41, 7'h41};
		for (int i = 0; i < 5; i++) begin
			wr_sp(tries[i], i != 4);
			chk("setpoint", 16'(want[i]), 16'(status.setpoint));
		end
	endtask
	// hottest sensor moves around, duty across the ramp
	task automatic t_duty();
		int temps [8] = '{60, 50, 49, 38, 26, 25, 0, -20};
		wr_sp(7'h32, 1'b1);
		for (int i = 0; i < 8; i++) begin
			hot_idx = 3'(i);
			hot = 8'(temps[i]);
			cool = 8'(temps[i] - 30);
			cyc(4);
			chk("hottest", 16'(hot), 16'(status.hottest));
			chk("auto duty", 16'(exp_duty(50, temps[i])), 16'(status.duty));
		end
		// software trades cooling for noise through the setpoint at a fixed 20 C
		hot = 8'h14;
		cool = 8'h00;
		wr_sp(7'h1e, 1'b1);
		chk("low setpoint duty", 16'(exp_duty(30, 20)), 16'(status.duty));
		wr_sp(7'h41, 1'b1);
		chk("high setpoint duty", 16'(exp_duty(65, 20)), 16'(status.duty));
	endtask
	// selector high forces full duty while cold
	task automatic t_high();
		speed_high_in = 1'b1;
		cyc(8);
		chk("high duty", 16'h0064, 16'(status.duty));
		speed_high_in = 1'b0;
		cyc(8);
		chk("auto duty back", 16'h0028, 16'(status.duty));
	endtask
	// one full pwm period at 40 percent
	task automatic t_pwm();
		int n = 0;
		repeat (5000) begin
			cyc(1);
			n += (fan_pwm === 1'b1);
		end
		chk("pwm high clocks", 16'h07d0, 16'(n));
	endtask
	// enable, sticky flag, clear, strict compare, third fan
	task automatic t_alarm();
		settings.limit = 16'h03e8;
		settings.limit_wr = 1'b1;
		cyc(1);
		settings.limit_wr = 1'b0;
		slow_fan = 2'h0;
		slow_rpm = 16'h03e7;
		cyc(4);
		chk("limit written", 16'h03e8, status.limit);
		chk("alarm disabled", 16'h0000, 16'(status.alarm));
		settings.alarm_en = 1'b1;
		wait_alarm();
		chk("alarm enable", 16'h0001, 16'(status.alarm_en));
		slow_rpm = 16'h03e8;
		cyc(4);
		chk("alarm held", 16'h0001, 16'(status.alarm));
		settings.alarm_clear = 1'b1;
		cyc(1);
		settings.alarm_clear = 1'b0;
		cyc(3);
		chk("alarm cleared", 16'h0000, 16'(status.alarm));
		slow_fan = 2'h2;
		slow_rpm = 16'h01f4;
		wait_alarm();
		// clear while the third fan is still slow: the set wins
		settings.alarm_clear = 1'b1;
		cyc(1);
		settings.alarm_clear = 1'b0;
		cyc(2);
		chk("alarm clear refused", 16'h0001, 16'(status.alarm));
	endtask

	// main sequence
	initial begin
		t_defaults();
		t_setpoint();
		t_duty();
		t_high();
		t_pwm();
		t_alarm();
		stop_test();
	end
endmodule // tb
